// ### logic/aop_port.sv
// Purpose: digital output and write-only register port of a 10-bit converter
// Assumes: pins sampled through two flops; core samples arrive on i_clock
// Notes: registers cannot be read back; outputs are registered
//
// Overview of operation
// - output enable low drives result, bit0 LSB
// - over-range flag driven only while enabled
// - unsigned default, two's complement when bit5 set
// - output enable high releases bus and flag
// - strobe high then low latches bus value, only while output enable is high
// - lines 9:8 address low, high, setup
// - registers are write-only, no readback path
// - low holds code 7:0, high 9:8
// - gain code bits 2:0, resets to 001
// - bit 3 requests sleep, resets zero
// - bit 4 selects clamp source, resets zero
// - bit 6 turns clamp off, resets zero
// - clamp code spans full 0..1023 range
// - clamp pin high forces input to reference
`timescale 1ns/1ps
`default_nettype none
module aop_port (
  input wire logic i_clock, // 200 MHz clock
  input wire logic i_rst, // sync reset, active high
  input wire logic [aop_pkg::DATA_W-1:0] i_sample, // raw core result, offset binary
  input wire logic i_sample_over, // core over-range for this sample
  input wire logic i_sample_valid, // core result strobe
  output logic o_sample_ready, // fifo has room, stalls core
  input wire logic i_output_enable_n, // output enable pin, active low
  input wire logic i_write_strobe, // latch strobe pin
  input wire logic [aop_pkg::DATA_W-1:0] i_bus, // bus lines, input side
  output logic [aop_pkg::DATA_W-1:0] o_bus, // bus lines, output side
  output logic o_bus_oe, // bus driver enable
  output logic o_over_range_flag, // over-range pin level
  output logic o_over_range_flag_oe, // over-range driver enable
  input wire logic i_clamp_pin, // clamp control pin
  output logic [aop_pkg::DATA_W-1:0] o_clamp_code, // clamp dac code
  output logic [2:0] o_gain_code, // amplifier gain code
  output logic o_sleep_request, // converter power-down
  output logic o_clamp_source_select, // 1 = internal dac
  output logic o_clamp_off, // clamp circuit disabled
  output logic o_clamp_active // clamp switch closed
);
  import aop_pkg::*;

  logic [1:0] oe_n_sync;
  logic [1:0] wr_sync;
  logic [1:0] clamp_sync;
  logic [DATA_W-1:0] bus_meta;
  logic [DATA_W-1:0] bus_sync;
  logic [7:0] clamp_code_low;
  logic [1:0] clamp_code_high;
  logic [7:0] converter_setup;
  aop_wr_state_t wr_state;
  aop_wr_state_t next_wr_state;
  logic write_fire;
  logic [DATA_W:0] fifo_out;
  logic fifo_valid;
  logic fifo_take;
  logic [DATA_W-1:0] next_bus;
  logic [1:0] write_addr;
  logic [7:0] write_data;
  logic sel_low;
  logic sel_high;
  logic sel_setup;
  logic outputs_on;

  // enable pin through two flops; reset value matches the released pin,
  // so no false enable follows reset
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      oe_n_sync <= 2'h3;
    end
    else
    begin
      oe_n_sync <= {oe_n_sync[0], i_output_enable_n};
    end
  end

  // strobe pin through two flops; idle low, so no false fall after reset
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      wr_sync <= 2'h0;
    end
    else
    begin
      wr_sync <= {wr_sync[0], i_write_strobe};
    end
  end

  // clamp pin through two flops
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      clamp_sync <= 2'h0;
    end
    else
    begin
      clamp_sync <= {clamp_sync[0], i_clamp_pin};
    end
  end

  // bus lines through two flops; same delay as the strobe, so the word
  // and its strobe edge line up; lines may skew, but the host holds them
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      bus_meta <= '0;
      bus_sync <= '0;
    end
    else
    begin
      bus_meta <= i_bus;
      bus_sync <= bus_meta;
    end
  end

  // one copy of the synchronised enable feeds every consumer
  assign outputs_on = !oe_n_sync[1];

  // write strobe tracker: capture on the falling edge of the strobe
  always_comb
  begin
    next_wr_state = wr_state;
    write_fire = 1'b0;
    case (wr_state)
      AOP_IDLE:
      begin
        if (wr_sync[1] && oe_n_sync[1])
        begin
          next_wr_state = AOP_STROBE;
        end
      end
      AOP_STROBE:
      begin
        if (!wr_sync[1])
        begin
          next_wr_state = AOP_IDLE;
          write_fire = oe_n_sync[1];
        end
      end
      default:
      begin
        next_wr_state = AOP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      wr_state <= AOP_IDLE;
    end
    else
    begin
      wr_state <= next_wr_state;
    end
  end

  // the two top lines pick the register; the low byte is its data
  assign write_addr = bus_sync[ADDR_MSB:ADDR_LSB];
  assign write_data = bus_sync[7:0];

  // address decode; the reserved code selects nothing, so such a write
  // is dropped rather than landing in a neighbour
  always_comb
  begin
    sel_low = 1'b0;
    sel_high = 1'b0;
    sel_setup = 1'b0;
    if (write_addr == ADDR_CLAMP_LOW)
    begin
      sel_low = write_fire;
    end
    else if (write_addr == ADDR_CLAMP_HIGH)
    begin
      sel_high = write_fire;
    end
    else if (write_addr == ADDR_SETUP)
    begin
      sel_setup = write_fire;
    end
  end

  // clamp code low byte; data is held past the strobe fall, so the
  // bus copy taken at the synchronised fall is stable
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      clamp_code_low <= CLAMP_LOW_RESET;
    end
    else if (sel_low)
    begin
      clamp_code_low <= write_data;
    end
  end

  // clamp code top bits; the upper six data lines are ignored
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      clamp_code_high <= CLAMP_HIGH_RESET;
    end
    else if (sel_high)
    begin
      clamp_code_high <= write_data[1:0];
    end
  end

  // setup word; bit 7 is stored but drives nothing
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      converter_setup <= SETUP_RESET;
    end
    else if (sel_setup)
    begin
      converter_setup <= write_data;
    end
  end

  // clamp dac code, registered so the dac sees one clean step per write
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_clamp_code <= {CLAMP_HIGH_RESET, CLAMP_LOW_RESET};
    end
    else
    begin
      o_clamp_code <= {clamp_code_high, clamp_code_low};
    end
  end

  // setup fields, registered from the stored word
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_gain_code <= SETUP_RESET[GAIN_MSB:GAIN_LSB];
      o_sleep_request <= 1'b0;
      o_clamp_source_select <= 1'b0;
      o_clamp_off <= 1'b0;
    end
    else
    begin
      o_gain_code <= converter_setup[GAIN_MSB:GAIN_LSB];
      o_sleep_request <= converter_setup[SLEEP_BIT];
      o_clamp_source_select <= converter_setup[CLAMP_SRC_BIT];
      o_clamp_off <= converter_setup[CLAMP_OFF_BIT];
    end
  end

  // clamp acts only while pin high and circuit not disabled
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_clamp_active <= 1'b0;
    end
    else
    begin
      o_clamp_active <= clamp_sync[1] && !converter_setup[CLAMP_OFF_BIT];
    end
  end

  // sample buffer; drains only while outputs are enabled, so it
  // fills and stalls the core while the host owns the bus
  aop_fifo #(
    .WIDTH(DATA_W + 1),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_data({i_sample_over, i_sample}),
    .i_valid(i_sample_valid),
    .o_ready(o_sample_ready),
    .o_data(fifo_out),
    .o_valid(fifo_valid),
    .i_ready(fifo_take)
  );

  assign fifo_take = outputs_on;

  // output coding: flipping the msb turns offset binary into two's complement
  always_comb
  begin
    if (converter_setup[SIGNED_BIT])
    begin
      next_bus = fifo_out[DATA_W-1:0] ^ SIGN_FLIP;
    end
    else
    begin
      next_bus = fifo_out[DATA_W-1:0];
    end
  end

  // result driver; no register value ever reaches o_bus, which keeps the
  // registers write-only; the last result stands while the fifo is empty
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_bus <= '0;
    end
    else if (outputs_on && fifo_valid)
    begin
      o_bus <= next_bus;
    end
  end

  // over-range flag travels with its sample
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_over_range_flag <= 1'b0;
    end
    else if (outputs_on && fifo_valid)
    begin
      o_over_range_flag <= fifo_out[DATA_W];
    end
  end

  // driver enables follow the synchronised enable pin; the host must
  // release first, since the three-flop delay (two sync flops and the enable flop) leaves a short overlap
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_bus_oe <= 1'b0;
      o_over_range_flag_oe <= 1'b0;
    end
    else
    begin
      o_bus_oe <= !oe_n_sync[1];
      o_over_range_flag_oe <= !oe_n_sync[1];
    end
  end
endmodule // aop_port
`default_nettype wire

// ### logic/aop_pkg.sv
// Purpose: shared constants for the converter output and register port
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes: register index is the value on the two top bus lines
package aop_pkg;
  localparam int DATA_W = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  // register addresses on bus lines 9:8
  localparam logic [1:0] ADDR_CLAMP_LOW = 2'h0;
  localparam logic [1:0] ADDR_CLAMP_HIGH = 2'h1;
  localparam logic [1:0] ADDR_SETUP = 2'h2;
  localparam logic [1:0] ADDR_RESERVED = 2'h3;
  // reset values
  localparam logic [7:0] CLAMP_LOW_RESET = 8'h00;
  localparam logic [1:0] CLAMP_HIGH_RESET = 2'h0;
  localparam logic [7:0] SETUP_RESET = 8'h01;
  // setup field positions
  localparam int GAIN_LSB = 0;
  localparam int GAIN_MSB = 2;
  localparam int SLEEP_BIT = 3;
  localparam int CLAMP_SRC_BIT = 4;
  localparam int SIGNED_BIT = 5;
  localparam int CLAMP_OFF_BIT = 6;
  localparam int ADDR_MSB = 9;
  localparam int ADDR_LSB = 8;
  localparam logic [9:0] SIGN_FLIP = 10'h200;
  typedef enum logic [1:0] {
    AOP_IDLE = 2'b00,
    AOP_STROBE = 2'b01
  } aop_wr_state_t;
endpackage

// ### logic/aop_fifo.sv
// Purpose: small synchronous fifo for conversion samples
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty derive from a count, so no slot is wasted
`timescale 1ns/1ps
`default_nettype none
module aop_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_clock, // system clock
  input wire logic i_rst, // sync reset
  input wire logic [WIDTH-1:0] i_data, // write data
  input wire logic i_valid, // write request
  output logic o_ready, // not full
  output logic [WIDTH-1:0] o_data, // head word
  output logic o_valid, // not empty
  input wire logic i_ready // read accept
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // handshakes on both sides
  assign o_valid = (count != '0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rd_ptr];

  // storage, flip-flops addressed by index
  always_ff @(posedge i_clock)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
    end
  end

  // next occupancy, shared by the counter and the registered ready
  always_comb
  begin
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_count = count - 1'b1;
    end
  end

  // ready from a flop, so the core sees a clean stall signal; it is
  // worked out from the next count and so has no extra cycle of lag
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      o_ready <= 1'b1;
    end
    else
    begin
      o_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule // aop_fifo
`default_nettype wire

// ### sim/aop_bus_model.sv
// Purpose: bus lines shared by host and port
// Assumes: one side drives at a time
// Notes: a floating bus flips each cycle
`timescale 1ns/1ps
`default_nettype none
module aop_bus_model (
  input wire logic i_clock, // clock
  input wire logic [9:0] i_dev, // port drive
  input wire logic i_dev_oe, // port enable
  input wire logic [9:0] i_host, // host drive
  input wire logic i_host_oe, // host enable
  output logic [9:0] o_level // line level
);
  logic [9:0] last = 10'h000;
  // a clash shows as unknown so it cannot hide
  always_comb
  begin
    if (i_dev_oe && i_host_oe)
      o_level = 10'hxxx;
    else if (i_dev_oe)
      o_level = i_dev;
    else if (i_host_oe)
      o_level = i_host;
    else
      o_level = ~last;
  end
  // kept so a release never looks like held data
  always_ff @(posedge i_clock)
    last <= o_level;
endmodule // aop_bus_model
`default_nettype wire

// ### sim/aop_port_props.sv
// Purpose: port checks of the converter port
// Assumes: pins pass two sync flops
// Notes: four cycles cover sync and output flops
`timescale 1ns/1ps
`default_nettype none
module aop_port_props (
  input wire logic i_clock, // in
  input wire logic i_rst, // in
  input wire logic i_output_enable_n, // in
  input wire logic i_write_strobe, // in
  input wire logic i_clamp_pin, // in
  input wire logic o_bus_oe, // in
  input wire logic o_over_range_flag_oe, // in
  input wire logic [aop_pkg::DATA_W-1:0] o_clamp_code, // in
  input wire logic [2:0] o_gain_code, // in
  input wire logic o_clamp_off, // in
  input wire logic o_clamp_active // in
);
  import aop_pkg::*;
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // pins held long enough to pass the sync flops
  sequence s_on;
    !i_output_enable_n [*4];
  endsequence
  sequence s_off;
    i_output_enable_n [*4];
  endsequence
  sequence s_quiet;
    !i_write_strobe [*8];
  endsequence
  flag_pair_a: assert property (o_bus_oe == o_over_range_flag_oe)
    else $error("flag enable split");
  bus_on_a: assert property (s_on |-> o_bus_oe)
    else $error("bus not driven");
  bus_off_a: assert property (s_off |-> !o_bus_oe)
    else $error("bus not released");
  no_strobe_a: assert property (s_quiet |-> $stable(o_clamp_code))
    else $error("code moved without strobe");
  no_write_a: assert property (!i_output_enable_n [*8] |-> $stable(o_gain_code))
    else $error("setup moved while driving");
  clamp_idle_a: assert property (!i_clamp_pin [*4] |-> !o_clamp_active)
    else $error("clamp active without pin");
  clamp_on_a: assert property ((i_clamp_pin && !o_clamp_off) [*4] |-> o_clamp_active)
    else $error("clamp not active");
  clamp_off_a: assert property (o_clamp_off [*2] |-> !o_clamp_active)
    else $error("disabled clamp active");
endmodule // aop_port_props
bind aop_port aop_port_props aop_port_props_inst (.i_clock(i_clock), .i_rst(i_rst),
  .i_output_enable_n(i_output_enable_n), .i_write_strobe(i_write_strobe),
  .i_clamp_pin(i_clamp_pin), .o_bus_oe(o_bus_oe), .o_over_range_flag_oe(o_over_range_flag_oe),
  .o_clamp_code(o_clamp_code), .o_gain_code(o_gain_code), .o_clamp_off(o_clamp_off),
  .o_clamp_active(o_clamp_active));
`default_nettype wire

// ### sim/testbench.sv
// Purpose: self-checking bench of the converter port
// Assumes: host drives only while outputs are released
// Notes: inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import aop_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sov = 1'b0, sv = 1'b0, oe_n = 1'b1;
  logic stb = 1'b0, clp = 1'b0, hoe = 1'b0;
  logic [9:0] smp = 10'h000, hbus = 10'h000;
  logic [9:0] lvl, dbus, code;
  logic [2:0] gain;
  logic rdy, doe, foe, flg, slp, src, off, act;
  int num_errors = 0;
  int samples_checked = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  aop_port aop_port_inst (.i_clock(clk), .i_rst(rst), .i_sample(smp), .i_sample_over(sov),
    .i_sample_valid(sv), .o_sample_ready(rdy), .i_output_enable_n(oe_n), .i_write_strobe(stb),
    .i_bus(lvl), .o_bus(dbus), .o_bus_oe(doe), .o_over_range_flag(flg),
    .o_over_range_flag_oe(foe), .i_clamp_pin(clp), .o_clamp_code(code), .o_gain_code(gain),
    .o_sleep_request(slp), .o_clamp_source_select(src), .o_clamp_off(off), .o_clamp_active(act));
  aop_bus_model aop_bus_model_inst (.i_clock(clk), .i_dev(dbus), .i_dev_oe(doe),
    .i_host(hbus), .i_host_oe(hoe), .o_level(lvl));
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // bus held past the fall, then released before outputs return
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    hoe = 1'b1;
    hbus = {a, d};
    stb = 1'b1;
    repeat (4) @(negedge clk);
    stb = 1'b0;
    repeat (4) @(negedge clk);
    hoe = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic t_clamp;
    chk("code", 10'h000, code);
    chk("gain", 10'h001, gain);
    chk("oe", 10'h000, doe);
    chk("flag_oe", 10'h000, foe);
    wr(2'h0, 8'h0f);
    wr(2'h1, 8'hfd);
    chk("code", 10'h10f, code);
    wr(2'h3, 8'hff);
    chk("code", 10'h10f, code);
    chk("gain", 10'h001, gain);
    wr(2'h0, 8'hff);
    wr(2'h1, 8'h03);
    chk("code", 10'h3ff, code);
  endtask
  task automatic t_setup;
    chk("sleep", 10'h000, slp);
    chk("src", 10'h000, src);
    chk("off", 10'h000, off);
    clp = 1'b1;
    wr(2'h2, 8'h7f);
    chk("gain", 10'h007, gain);
    chk("sleep", 10'h001, slp);
    chk("src", 10'h001, src);
    chk("act", 10'h000, act);
    wr(2'h2, 8'h06);
    chk("gain", 10'h006, gain);
    chk("off", 10'h000, off);
    chk("act", 10'h001, act);
    clp = 1'b0;
  endtask
  // fill until refused, then drain with outputs on
  task automatic t_data(input logic sg);
    int i;
    wr(2'h2, {2'h0, sg, 5'h01});
    for (i = 0; i <= 16; i++)
    begin
      chk("ready", i < 16, rdy);
      smp = 10'(i * 67);
      sov = i[0];
      sv = i < 16;
      @(negedge clk);
    end
    oe_n = 1'b0;
    for (i = 0; i < 9 && doe !== 1'b1; i++)
      @(negedge clk);
    chk("oe", 10'h001, doe);
    chk("flag_oe", 10'h001, foe);
    for (i = 0; i < 16; i++)
    begin
      chk("data", 10'(i * 67) ^ (sg ? SIGN_FLIP : 10'h000), lvl);
      chk("flag", i[0], flg);
      @(negedge clk);
    end
    oe_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("oe", 10'h000, doe);
    chk("flag_oe", 10'h000, foe);
    chk("ready", 10'h001, rdy);
  endtask
  task end_sim;
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_clamp();
    t_setup();
    t_data(1'b0);
    t_data(1'b1);
    end_sim();
  end
  // run needs about 1 us
  initial
  begin
    #20us;
    num_errors++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire
